// *** dcmi_regs.svh ***
// constants for the dual channel memory interface
`ifndef DCMI_REGS_SVH
`define DCMI_REGS_SVH

// pin widths
`define DCMI_ADDR_W 12
`define DCMI_DATA_W 32
`define DCMI_HALF_W 16
`define DCMI_LANES 4
`define DCMI_HALF_LANES 2
`define DCMI_DEV_W 2
`define DCMI_NUM_DEV 4
`define DCMI_NUM_CHAN 2
// address bit that selects all banks on precharge
`define DCMI_AP_BIT 10

// timing, in ns and in memory clock steps
`define DCMI_CORE_PERIOD_NS 5
`define DCMI_STEP_NS (2 * `DCMI_CORE_PERIOD_NS)
`define DCMI_T_RCD_NS 20
`define DCMI_T_RP_NS 20
`define DCMI_CAS_LAT 2
`define DCMI_WAIT_W 4
`define DCMI_RCD_STEPS ((`DCMI_T_RCD_NS + `DCMI_STEP_NS - 1) / `DCMI_STEP_NS)
`define DCMI_RP_STEPS ((`DCMI_T_RP_NS + `DCMI_STEP_NS - 1) / `DCMI_STEP_NS)

`endif

// *** dcmi_pkg.sv ***
// types shared by the dual channel memory interface
package dcmi_pkg;
  `include "dcmi_regs.svh"

  // kind of memory attached to both channels
  typedef enum logic [1:0] {
    DCMI_SDRAM,
    DCMI_SGRAM,
    DCMI_DRAM
  } dcmi_mode_t;

  // per-channel access sequencer states
  typedef enum logic [3:0] {
    ST_IDLE,
    ST_MODE_SET,
    ST_ACT,
    ST_RCD,
    ST_COL,
    ST_LAT,
    ST_CAP,
    ST_PUSH,
    ST_PRE,
    ST_RP
  } dcmi_state_t;

  // one access request from the core
  typedef struct packed {
    logic write;
    logic mode_set;
    logic [`DCMI_DEV_W-1:0] dev;
    logic [`DCMI_ADDR_W-1:0] row;
    logic [`DCMI_ADDR_W-1:0] col;
    logic [`DCMI_DATA_W-1:0] wdata;
    logic [`DCMI_LANES-1:0] byte_en;
  } dcmi_req_t;

  // memory pins of one channel, two-way data as out and enable
  typedef struct packed {
    logic [`DCMI_NUM_DEV-1:0] select_n;
    logic [`DCMI_ADDR_W-1:0] addr;
    logic row_strobe_n;
    logic col_strobe_n;
    logic write_en_n;
    logic [`DCMI_LANES-1:0] lane_mask_n;
    logic [`DCMI_DATA_W-1:0] data_out;
    logic [`DCMI_DATA_W-1:0] data_oe;
  } dcmi_pins_t;
endpackage

// *** dcmi_buf.sv ***
// two-entry buffer with valid and ready on both sides
`timescale 1ns/100ps
module dcmi_buf #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // fill side
  input wire logic i_in_valid,
  output logic o_in_ready,
  input wire logic [WIDTH-1:0] i_in_data,
  // drain side
  output logic o_out_valid,
  input wire logic i_out_ready,
  output logic [WIDTH-1:0] o_out_data
);
  logic [WIDTH-1:0] e0_reg;
  logic [WIDTH-1:0] e1_reg;
  logic v0_reg;
  logic v1_reg;
  logic push;
  logic pop;

  // handshakes on both sides
  assign push = i_in_valid && !v1_reg;
  assign pop = v0_reg && i_out_ready;
  assign o_in_ready = !v1_reg;
  assign o_out_valid = v0_reg;
  assign o_out_data = e0_reg;

  // entry bookkeeping, head is always entry 0
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      e0_reg <= '0;
      e1_reg <= '0;
      v0_reg <= 1'b0;
      v1_reg <= 1'b0;
    end else begin
      case ({push, pop})
        2'h2: begin
          if (!v0_reg) begin
            e0_reg <= i_in_data;
            v0_reg <= 1'b1;
          end else begin
            e1_reg <= i_in_data;
            v1_reg <= 1'b1;
          end
        end
        2'h1: begin
          e0_reg <= e1_reg;
          v0_reg <= v1_reg;
          v1_reg <= 1'b0;
        end
        2'h3: begin
          if (v1_reg) begin
            e0_reg <= e1_reg;
            e1_reg <= i_in_data;
          end else begin
            e0_reg <= i_in_data;
          end
        end
        default: begin
          e0_reg <= e0_reg;
        end
      endcase
    end
  end
endmodule

// *** dcmi_capture.sv ***
// read data capture on the looped-back memory clock
`timescale 1ns/100ps
module dcmi_capture #(
  parameter int WIDTH = 32
) (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // pins
  input wire logic i_capture_clock,
  input wire logic [WIDTH-1:0] i_data,
  // captured word
  output logic o_pulse,
  output logic [WIDTH-1:0] o_data
);
  logic clk_s1_reg;
  logic clk_s2_reg;
  logic clk_s3_reg;
  logic [WIDTH-1:0] dat_s1_reg;
  logic [WIDTH-1:0] dat_s2_reg;
  logic pulse_reg;
  logic [WIDTH-1:0] data_reg;

  assign o_pulse = pulse_reg;
  assign o_data = data_reg;

  // two-stage synchronisers for clock and data pins
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      clk_s1_reg <= 1'b0;
      clk_s2_reg <= 1'b0;
      clk_s3_reg <= 1'b0;
      dat_s1_reg <= '0;
      dat_s2_reg <= '0;
    end else begin
      clk_s1_reg <= i_capture_clock;
      clk_s2_reg <= clk_s1_reg;
      clk_s3_reg <= clk_s2_reg;
      dat_s1_reg <= i_data;
      dat_s2_reg <= dat_s1_reg;
    end
  end

  // latch data on each rising edge of the loop clock
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      pulse_reg <= 1'b0;
      data_reg <= '0;
    end else begin
      pulse_reg <= clk_s2_reg && !clk_s3_reg;
      if (clk_s2_reg && !clk_s3_reg) begin
        data_reg <= dat_s2_reg;
      end
    end
  end
endmodule

// *** dcmi_top.sv ***
// dual channel memory interface: sequencers, pins and read paths
`timescale 1ns/100ps
`include "dcmi_regs.svh"
module dcmi_top (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // configuration
  input wire dcmi_pkg::dcmi_mode_t i_mem_mode,
  input wire logic i_half_width,
  // requests, bit 0 channel a, bit 1 channel b
  input wire logic [`DCMI_NUM_CHAN-1:0] i_req_valid,
  output logic [`DCMI_NUM_CHAN-1:0] o_req_ready,
  input wire dcmi_pkg::dcmi_req_t i_req_a,
  input wire dcmi_pkg::dcmi_req_t i_req_b,
  // read data
  output logic [`DCMI_NUM_CHAN-1:0] o_rd_valid,
  input wire logic [`DCMI_NUM_CHAN-1:0] i_rd_ready,
  output logic [`DCMI_DATA_W-1:0] o_rd_data_a,
  output logic [`DCMI_DATA_W-1:0] o_rd_data_b,
  // channel a pins
  output dcmi_pkg::dcmi_pins_t o_chan_a_pins,
  input wire logic [`DCMI_DATA_W-1:0] i_chan_a_data,
  output logic o_chan_a_mem_clock_out,
  input wire logic i_chan_a_capture_clock,
  // channel b pins
  output dcmi_pkg::dcmi_pins_t o_chan_b_pins,
  input wire logic [`DCMI_DATA_W-1:0] i_chan_b_data,
  output logic o_chan_b_mem_clock_out,
  input wire logic i_chan_b_capture_clock
);
  logic mem_clk_reg;
  logic clk_a_reg;
  logic clk_b_reg;
  logic step;
  logic half_en;
  logic dram;
  dcmi_pkg::dcmi_req_t req_in [`DCMI_NUM_CHAN];
  logic [`DCMI_DATA_W-1:0] pin_data [`DCMI_NUM_CHAN];
  logic cap_clk [`DCMI_NUM_CHAN];
  logic [`DCMI_DATA_W-1:0] rd_out [`DCMI_NUM_CHAN];

  // one-hot active-low device select
  function automatic logic [`DCMI_NUM_DEV-1:0] sel_decode(
    input logic [`DCMI_DEV_W-1:0] dev
  );
    logic [`DCMI_NUM_DEV-1:0] s;
    s = '1;
    s[dev] = 1'b0;
    return s;
  endfunction

  // pin levels for a sequencer state
  function automatic dcmi_pkg::dcmi_pins_t pins_for(
    input dcmi_pkg::dcmi_state_t st,
    input dcmi_pkg::dcmi_req_t r,
    input logic is_dram,
    input logic half
  );
    dcmi_pkg::dcmi_pins_t p;
    p.select_n = '1;
    p.addr = '0;
    p.row_strobe_n = 1'b1;
    p.col_strobe_n = 1'b1;
    p.write_en_n = 1'b1;
    p.lane_mask_n = '1;
    p.data_out = '0;
    p.data_oe = '0;
    case (st)
      dcmi_pkg::ST_MODE_SET: begin
        p.select_n = sel_decode(r.dev);
        p.addr = r.row;
        p.row_strobe_n = 1'b0;
        p.col_strobe_n = is_dram;
        p.write_en_n = 1'b0;
      end
      dcmi_pkg::ST_ACT: begin
        p.select_n = sel_decode(r.dev);
        p.addr = r.row;
        p.row_strobe_n = 1'b0;
      end
      dcmi_pkg::ST_RCD: begin
        if (is_dram) begin
          p.select_n = sel_decode(r.dev);
          p.row_strobe_n = 1'b0;
          p.addr = r.col;
        end
      end
      dcmi_pkg::ST_COL: begin
        p.select_n = sel_decode(r.dev);
        p.addr = r.col;
        // write enable same in all modes
        p.write_en_n = !r.write;
        if (is_dram) begin
          // lanes act as per-byte column strobes
          p.row_strobe_n = 1'b0;
          p.lane_mask_n = ~r.byte_en;
        end else begin
          p.col_strobe_n = 1'b0;
          p.lane_mask_n = r.write ? ~r.byte_en : '0;
        end
        if (r.write) begin
          p.data_out = r.wdata;
          p.data_oe = '1;
        end
      end
      dcmi_pkg::ST_LAT, dcmi_pkg::ST_CAP, dcmi_pkg::ST_PUSH: begin
        if (is_dram) begin
          // column strobes held while read data settles
          p.select_n = sel_decode(r.dev);
          p.row_strobe_n = 1'b0;
          p.addr = r.col;
          p.lane_mask_n = ~r.byte_en;
        end else begin
          p.lane_mask_n = '0;
        end
      end
      dcmi_pkg::ST_PRE: begin
        // precharge by row strobe and write enable
        if (!is_dram) begin
          p.select_n = sel_decode(r.dev);
          p.row_strobe_n = 1'b0;
          p.write_en_n = 1'b0;
          p.addr[`DCMI_AP_BIT] = 1'b1;
        end
      end
      default: begin
        p.select_n = '1;
      end
    endcase
    // upper half idle in 16-bit mode
    if (half) begin
      p.lane_mask_n[`DCMI_LANES-1:`DCMI_HALF_LANES] = '1;
      p.data_oe[`DCMI_DATA_W-1:`DCMI_HALF_W] = '0;
      p.data_out[`DCMI_DATA_W-1:`DCMI_HALF_W] = '0;
    end
    return p;
  endfunction

  // configuration decode, 16-bit only allowed with sdram
  assign dram = (i_mem_mode == dcmi_pkg::DCMI_DRAM);
  assign half_en = i_half_width && (i_mem_mode == dcmi_pkg::DCMI_SDRAM);
  assign step = mem_clk_reg;

  // per-channel input routing
  assign req_in[0] = i_req_a;
  assign req_in[1] = i_req_b;
  assign pin_data[0] = i_chan_a_data;
  assign pin_data[1] = i_chan_b_data;
  assign cap_clk[0] = i_chan_a_capture_clock;
  assign cap_clk[1] = i_chan_b_capture_clock;
  assign o_rd_data_a = rd_out[0];
  assign o_rd_data_b = rd_out[1];
  assign o_chan_a_mem_clock_out = clk_a_reg;
  assign o_chan_b_mem_clock_out = clk_b_reg;

  // memory clock at half core rate
  always_ff @(posedge i_core_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      mem_clk_reg <= 1'b0;
      clk_a_reg <= 1'b0;
      clk_b_reg <= 1'b0;
    end else begin
      mem_clk_reg <= !mem_clk_reg;
      clk_a_reg <= !mem_clk_reg;
      clk_b_reg <= !mem_clk_reg;
    end
  end

  for (genvar g = 0; g < `DCMI_NUM_CHAN; g++) begin : g_chan
    dcmi_pkg::dcmi_state_t st_reg;
    dcmi_pkg::dcmi_state_t st_next;
    logic [`DCMI_WAIT_W-1:0] wait_reg;
    logic [`DCMI_WAIT_W-1:0] wait_next;
    dcmi_pkg::dcmi_req_t cur_reg;
    dcmi_pkg::dcmi_req_t cur_next;
    dcmi_pkg::dcmi_pins_t pin_reg;
    logic rdy_reg;
    logic [`DCMI_DATA_W-1:0] rd_reg;
    logic cap_pulse;
    logic [`DCMI_DATA_W-1:0] cap_data;
    logic buf_ready;
    logic push;

    dcmi_capture #(
      .WIDTH(`DCMI_DATA_W)
    ) u_cap (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_capture_clock(cap_clk[g]),
      .i_data(pin_data[g]),
      .o_pulse(cap_pulse),
      .o_data(cap_data)
    );

    // read words wait here while the receiver stalls
    dcmi_buf #(
      .WIDTH(`DCMI_DATA_W)
    ) u_buf (
      .i_core_clk(i_core_clk),
      .i_rst_b(i_rst_b),
      .i_in_valid(push),
      .o_in_ready(buf_ready),
      .i_in_data(rd_reg),
      .o_out_valid(o_rd_valid[g]),
      .i_out_ready(i_rd_ready[g]),
      .o_out_data(rd_out[g])
    );

    assign push = step && (st_reg == dcmi_pkg::ST_PUSH);
    assign o_req_ready[g] = rdy_reg;

    // sequencer next state
    always_comb begin
      st_next = st_reg;
      wait_next = wait_reg;
      cur_next = cur_reg;
      case (st_reg)
        dcmi_pkg::ST_IDLE: begin
          if (step && rdy_reg && i_req_valid[g]) begin
            cur_next = req_in[g];
            st_next = req_in[g].mode_set ? dcmi_pkg::ST_MODE_SET : dcmi_pkg::ST_ACT;
          end
        end
        dcmi_pkg::ST_MODE_SET, dcmi_pkg::ST_PRE: begin
          if (step) begin
            st_next = dcmi_pkg::ST_RP;
            wait_next = `DCMI_WAIT_W'(`DCMI_RP_STEPS - 1);
          end
        end
        dcmi_pkg::ST_ACT: begin
          if (step) begin
            st_next = dcmi_pkg::ST_RCD;
            wait_next = `DCMI_WAIT_W'(`DCMI_RCD_STEPS - 1);
          end
        end
        dcmi_pkg::ST_RCD, dcmi_pkg::ST_LAT, dcmi_pkg::ST_RP: begin
          if (step) begin
            if (wait_reg != '0) begin
              wait_next = wait_reg - 1'b1;
            end else if (st_reg == dcmi_pkg::ST_RCD) begin
              st_next = dcmi_pkg::ST_COL;
            end else if (st_reg == dcmi_pkg::ST_LAT) begin
              st_next = dcmi_pkg::ST_CAP;
            end else begin
              st_next = dcmi_pkg::ST_IDLE;
            end
          end
        end
        dcmi_pkg::ST_COL: begin
          if (step) begin
            st_next = cur_reg.write ? dcmi_pkg::ST_PRE : dcmi_pkg::ST_LAT;
            wait_next = `DCMI_WAIT_W'(`DCMI_CAS_LAT - 1);
          end
        end
        dcmi_pkg::ST_CAP: begin
          if (cap_pulse) begin
            st_next = dcmi_pkg::ST_PUSH;
          end
        end
        dcmi_pkg::ST_PUSH: begin
          if (push && buf_ready) begin
            st_next = dcmi_pkg::ST_PRE;
          end
        end
        default: begin
          st_next = dcmi_pkg::ST_IDLE;
        end
      endcase
    end

    // sequencer state, timer and held request
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        st_reg <= dcmi_pkg::ST_IDLE;
        wait_reg <= '0;
        cur_reg <= '0;
      end else begin
        st_reg <= st_next;
        wait_reg <= wait_next;
        cur_reg <= cur_next;
      end
    end

    // request ready only in the cycle a command may start
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        rdy_reg <= 1'b0;
      end else begin
        rdy_reg <= !mem_clk_reg && (st_next == dcmi_pkg::ST_IDLE);
      end
    end

    // read word taken from the capture path
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        rd_reg <= '0;
      end else if (st_reg == dcmi_pkg::ST_CAP && cap_pulse) begin
        rd_reg <= cap_data;
        if (half_en) begin
          rd_reg[`DCMI_DATA_W-1:`DCMI_HALF_W] <= '0;
        end
      end
    end

    // pins idle and undriven under reset
    always_ff @(posedge i_core_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
        pin_reg <= '{select_n: '1, row_strobe_n: 1'b1, col_strobe_n: 1'b1,
          write_en_n: 1'b1, lane_mask_n: '1, default: '0};
      end else if (step) begin
        pin_reg <= pins_for(st_next, cur_next, dram, half_en);
      end
    end
  end

  // pin bundles straight from the channel flops
  assign o_chan_a_pins = g_chan[0].pin_reg;
  assign o_chan_b_pins = g_chan[1].pin_reg;
endmodule

// *** dcmi_checker.sv ***
// pin assertions for the dual channel memory interface
`timescale 1ns/100ps
`include "dcmi_regs.svh"
module dcmi_checker (
  // clock and reset
  input wire logic i_core_clk,
  input wire logic i_rst_b,
  // watched ports
  input wire dcmi_pkg::dcmi_mode_t i_mem_mode,
  input wire logic i_half_width,
  input wire logic [1:0] i_req_valid,
  input wire logic [1:0] o_req_ready,
  input wire dcmi_pkg::dcmi_req_t i_req_a,
  input wire logic [1:0] o_rd_valid,
  input wire logic [1:0] i_rd_ready,
  input wire logic [31:0] o_rd_data_a,
  input wire dcmi_pkg::dcmi_pins_t o_chan_a_pins,
  input wire dcmi_pkg::dcmi_pins_t o_chan_b_pins,
  input wire logic o_chan_a_mem_clock_out
);
  dcmi_pkg::dcmi_pins_t pa;
  logic sync_m;
  logic take_a;
  logic [11:0] row_a;
  logic [1:0] dev_a;
  // short names for the watched pins
  assign pa = o_chan_a_pins;
  assign sync_m = i_mem_mode != dcmi_pkg::DCMI_DRAM;
  assign take_a = i_req_valid[0] && o_req_ready[0];
  assign row_a = i_req_a.row;
  assign dev_a = i_req_a.dev;
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (!i_rst_b);
  // row activate and column command in synchronous modes
  sequence s_act;
    sync_m && pa.select_n != 4'hf && $fell(pa.row_strobe_n) && pa.col_strobe_n && pa.write_en_n;
  endsequence
  sequence s_col;
    !pa.col_strobe_n && pa.row_strobe_n;
  endsequence
  AST_SEL_A: assert property ($onehot0(~pa.select_n))
    else $error("channel a selects more than one device");
  AST_SEL_B: assert property ($onehot0(~o_chan_b_pins.select_n))
    else $error("channel b selects more than one device");
  AST_TAKE_SEL: assert property (take_a && !i_req_a.mode_set |=>
    pa.select_n == ~(4'h1 << $past(dev_a))) else $error("select does not match device");
  AST_TAKE_ADDR: assert property (take_a |=> pa.addr == $past(row_a))
    else $error("address differs from request row");
  AST_PRE_AP: assert property (sync_m && !pa.row_strobe_n && pa.col_strobe_n &&
    !pa.write_en_n |-> pa.addr[10]) else $error("precharge without all-bank bit");
  AST_ACT_COL: assert property (s_act |-> ##6 s_col)
    else $error("column command not six cycles after activate");
  AST_RD_MASK: assert property (sync_m && !i_half_width && !pa.col_strobe_n &&
    pa.row_strobe_n && pa.write_en_n |-> pa.lane_mask_n == 4'h0 && pa.data_oe == 32'h0)
    else $error("read column with lanes masked or bus driven");
  AST_DRAM_CAS: assert property (i_mem_mode == dcmi_pkg::DCMI_DRAM |-> pa.col_strobe_n)
    else $error("column strobe pin used in dram mode");
  AST_HALF: assert property (i_mem_mode == dcmi_pkg::DCMI_SDRAM && i_half_width |->
    pa.data_oe[31:16] == 16'h0) else $error("upper half driven in half width");
  AST_WR_OE: assert property (sync_m && !i_half_width && !pa.col_strobe_n &&
    pa.row_strobe_n && !pa.write_en_n |-> pa.data_oe == 32'hffffffff)
    else $error("write column does not drive full bus");
  AST_CLK: assert property (1'b1 |=> o_chan_a_mem_clock_out != $past(o_chan_a_mem_clock_out))
    else $error("memory clock stopped");
  AST_RST_IDLE: assert property ($rose(i_rst_b) |-> pa.select_n == 4'hf &&
    pa.row_strobe_n && pa.col_strobe_n && pa.write_en_n && pa.data_oe == 32'h0)
    else $error("pins not idle in reset");
  AST_RD_HOLD: assert property (o_rd_valid[0] && !i_rd_ready[0] |=>
    o_rd_valid[0] && $stable(o_rd_data_a)) else $error("read word lost in stall");
endmodule

bind dcmi_top dcmi_checker u_chk (.i_core_clk, .i_rst_b, .i_mem_mode, .i_half_width,
  .i_req_valid, .o_req_ready, .i_req_a, .o_rd_valid, .i_rd_ready, .o_rd_data_a,
  .o_chan_a_pins, .o_chan_b_pins, .o_chan_a_mem_clock_out);

// *** dcmi_mem_model.sv ***
// behavioural memory devices on one channel
`timescale 1ns/100ps
module dcmi_mem_model (
  // memory clock and mode
  input wire logic i_mem_clk,
  input wire dcmi_pkg::dcmi_mode_t i_mem_mode,
  // pins from the controller
  input wire dcmi_pkg::dcmi_pins_t i_pins,
  // resolved data wire
  output logic [31:0] o_data
);
  logic [31:0] mem [64];
  logic [31:0] last;
  logic [31:0] rd;
  logic [5:0] idx;
  logic drv;
  logic is_dram;
  logic col;
  dcmi_pkg::dcmi_pins_t p;
  assign p = i_pins;
  assign is_dram = i_mem_mode == dcmi_pkg::DCMI_DRAM;
  assign rd = mem[idx];
  // column by strobe pin or byte lanes
  assign col = is_dram ? (!p.row_strobe_n && p.lane_mask_n != 4'hf) :
    (p.row_strobe_n && !p.col_strobe_n && p.select_n != 4'hf);
  // known contents before the first write
  initial begin
    for (int i = 0; i < 64; i++) begin
      mem[i] = 32'h0;
    end
    drv = 1'b0;
    last = 32'h0;
    idx = 6'h0;
  end
  // commands seen on memory clock, dram strobes stand a full step
  always @(posedge i_mem_clk) begin
    if (col) begin
      idx <= {~p.select_n, p.addr[1:0]};
      drv <= p.write_en_n;
      for (int b = 0; b < 4; b++) begin
        if (!p.write_en_n && !p.lane_mask_n[b]) begin
          mem[{~p.select_n, p.addr[1:0]}][8*b +: 8] <= o_data[8*b +: 8];
        end
      end
    end else if (is_dram ? p.row_strobe_n : (!p.row_strobe_n && p.write_en_n == 1'b0)) begin
      drv <= 1'b0;
    end
    if (drv) begin
      last <= rd;
    end
  end
  // wire level: controller, memory, else inverted leftovers
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      o_data[i] = p.data_oe[i] ? p.data_out[i] : (drv ? rd[i] : ~last[i]);
    end
  end
endmodule

// *** tb_dual_channel_memory_interface.sv ***
// testbench for the dual channel memory interface
`timescale 1ns/100ps
`include "dcmi_regs.svh"
module tb_dual_channel_memory_interface;
  logic clk;
  logic rst_b;
  dcmi_pkg::dcmi_mode_t mode;
  logic half;
  logic [1:0] req_valid;
  wire logic [1:0] req_ready;
  dcmi_pkg::dcmi_req_t req [2];
  wire logic [1:0] rd_valid;
  logic [1:0] rd_ready;
  wire logic [31:0] rd_data [2];
  wire dcmi_pkg::dcmi_pins_t pins [2];
  wire logic [31:0] dq [2];
  wire logic mclk [2];
  int err_count;
  int samples_checked;
  int cyc;
  // design, capture clocks looped back from memory clocks
  dcmi_top DUT (.i_core_clk(clk), .i_rst_b(rst_b), .i_mem_mode(mode), .i_half_width(half),
    .i_req_valid(req_valid), .o_req_ready(req_ready), .i_req_a(req[0]), .i_req_b(req[1]),
    .o_rd_valid(rd_valid), .i_rd_ready(rd_ready), .o_rd_data_a(rd_data[0]),
    .o_rd_data_b(rd_data[1]), .o_chan_a_pins(pins[0]), .i_chan_a_data(dq[0]),
    .o_chan_a_mem_clock_out(mclk[0]), .i_chan_a_capture_clock(mclk[0]),
    .o_chan_b_pins(pins[1]), .i_chan_b_data(dq[1]), .o_chan_b_mem_clock_out(mclk[1]),
    .i_chan_b_capture_clock(mclk[1]));
  dcmi_mem_model u_mem_a (.i_mem_clk(mclk[0]), .i_mem_mode(mode), .i_pins(pins[0]),
    .o_data(dq[0]));
  dcmi_mem_model u_mem_b (.i_mem_clk(mclk[1]), .i_mem_mode(mode), .i_pins(pins[1]),
    .o_data(dq[1]));
  // core clock
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // hang guard
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      err_count++;
      test_done();
    end
  end
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one request, held until taken, pins checked after the taking edge
  task automatic do_req(input int ch, input logic w, input logic [1:0] dev,
      input logic [11:0] a, input logic [31:0] d, input logic [3:0] be, input logic ms);
    int n;
    n = 0;
    @(negedge clk);
    req[ch] = '{write: w, mode_set: ms, dev: dev, row: a, col: a, wdata: d, byte_en: be};
    req_valid[ch] = 1'b1;
    while (req_ready[ch] !== 1'b1 && n < 200) begin
      @(negedge clk);
      n++;
    end
    @(posedge clk);
    #1;
    check({20'h0, pins[ch].addr}, {20'h0, a});
    if (!ms) check({28'h0, pins[ch].select_n}, {28'h0, ~(4'h1 << dev)});
    @(negedge clk);
    req_valid[ch] = 1'b0;
  endtask
  task automatic read_word(input int ch, input logic [31:0] exp);
    int n;
    n = 0;
    while (rd_valid[ch] !== 1'b1 && n < 400) begin
      @(negedge clk);
      n++;
    end
    check(rd_data[ch], exp);
    @(negedge clk);
  endtask
  task automatic t_reset();
    for (int c = 0; c < 2; c++) begin
      check({21'h0, pins[c].select_n, pins[c].row_strobe_n, pins[c].col_strobe_n,
        pins[c].write_en_n, pins[c].lane_mask_n}, 32'h7ff);
      check(pins[c].data_oe, 32'h0);
    end
    $display("test reset done");
  endtask
  task automatic t_clock();
    logic m0;
    logic m1;
    @(negedge clk);
    m0 = mclk[0];
    m1 = mclk[1];
    @(negedge clk);
    check({31'h0, mclk[0] ^ m0}, 32'h1);
    check({31'h0, mclk[1] ^ m1}, 32'h1);
    $display("test clock done");
  endtask
  // full and partial writes then read, every mode, both channels
  task automatic t_rw();
    logic [31:0] e;
    for (int m = 0; m < 3; m++) begin
      mode = dcmi_pkg::dcmi_mode_t'(m);
      repeat (20) @(negedge clk);
      for (int c = 0; c < 2; c++) begin
        e = 32'h11223344 ^ m;
        do_req(c, 1'b1, 2'(1 + 2 * c), 12'h001, e, 4'hf, 1'b0);
        do_req(c, 1'b1, 2'(1 + 2 * c), 12'h001, 32'haabbccdd, 4'h5, 1'b0);
        do_req(c, 1'b0, 2'(1 + 2 * c), 12'h001, 32'h0, 4'hf, 1'b0);
        read_word(c, {e[31:24], 8'hbb, e[15:8], 8'hdd});
      end
    end
    $display("test read write done");
  endtask
  // half width honoured in sdram, ignored in dram
  task automatic t_half();
    half = 1'b1;
    for (int m = 0; m < 2; m++) begin
      mode = m == 0 ? dcmi_pkg::DCMI_SDRAM : dcmi_pkg::DCMI_DRAM;
      repeat (20) @(negedge clk);
      do_req(0, 1'b1, 2'h0, 12'h002, 32'hcafe1234, 4'hf, 1'b0);
      do_req(0, 1'b0, 2'h0, 12'h002, 32'h0, 4'hf, 1'b0);
      read_word(0, m == 0 ? 32'h00001234 : 32'hcafe1234);
    end
    half = 1'b0;
    $display("test half width done");
  endtask
  // mode set, then three reads into a stalled two-entry buffer
  task automatic t_stall();
    mode = dcmi_pkg::DCMI_SDRAM;
    repeat (20) @(negedge clk);
    do_req(0, 1'b0, 2'h0, 12'h022, 32'h0, 4'h0, 1'b1);
    for (int i = 0; i < 3; i++) begin
      do_req(0, 1'b1, 2'h2, 12'(i), 32'h0f0f0000 + i, 4'hf, 1'b0);
    end
    rd_ready[0] = 1'b0;
    for (int i = 0; i < 3; i++) begin
      do_req(0, 1'b0, 2'h2, 12'(i), 32'h0, 4'hf, 1'b0);
    end
    repeat (30) @(negedge clk);
    check({31'h0, rd_valid[0]}, 32'h1);
    rd_ready[0] = 1'b1;
    for (int i = 0; i < 3; i++) read_word(0, 32'h0f0f0000 + i);
    $display("test stall done");
  endtask
  task automatic test_done();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    err_count = 0;
    samples_checked = 0;
    cyc = 0;
    rst_b = 1'b0;
    mode = dcmi_pkg::DCMI_SDRAM;
    half = 1'b0;
    req_valid = 2'h0;
    rd_ready = 2'h3;
    req[0] = '0;
    req[1] = '0;
    repeat (4) @(negedge clk);
    t_reset();
    rst_b = 1'b1;
    t_clock();
    t_rw();
    t_half();
    t_stall();
    test_done();
  end
endmodule
